// ### logic/rf_defect_loops.sv
// Our own choices: the address map and the AHB-Lite slave port.
`default_nettype none
// Contract
// R01 - Offset requests integrate; analog offset moves only on averaged demand.
// R02 - One offset step of hysteresis between integrator and applied value.
// R03 - Offset value register is writable; reads return the applied value.
// R04 - Software programs offset loop integration bandwidth.
// R05 - Applied offset value is clamped between programmable upper and lower bounds.
// R06 - Gain loop and offset loop have separate enables.
// R07 - Slow mode divides a loop's programmed bandwidth by a further 128.
// R08 - With hold-only-when-locked set, no loop hold while PLL unlocked.
// R09 - Software keeps amplitude thresholds at least two gain steps apart.
// R10 - Software keeps the offset window no tighter than plus or minus 8.
// R11 - Defect amplitude comes from decay peak detectors with programmable bandwidths.
// R12 - Defect flag sets as soon as amplitude falls below low threshold.
// R13 - Defect flag clears only when amplitude rises above high threshold.
// R14 - Per-target enables pick PLL, slicer, gain, offset, filter holds on defect.
// R15 - Same register forces PLL, slicer and filter hold regardless of defect.
// R16 - Disabled gain or offset loop acts as hold and keeps its value.
// R17 - Processed defect asserts after start delay; shorter defects ignored.
// R18 - Processed defect clears after stop delay; shorter good gaps ignored.
// R19 - Holds follow processed defect; with zero delays it equals raw flag.
// R20 - After a defect, a programmed window selects faster PLL or slicer bandwidth.
// R21 - Maskable interrupts on defect start and end, raw or processed.
// R22 - Offset above window requests lower value, below requests higher; invert bit flips.
// R23 - Offset value spans 32 steps each side of zero.
// R24 - Gain rises below lower threshold, falls above upper threshold or on clipping.
// R25 - A held loop freezes integrator and value, then resumes from there.
module rf_defect_loops #(
  parameter int DLY_W = 16,
  parameter int WIN_W = 16
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Measurements from the front end
  input  wire rf_loop_pkg::meas_t   meas,
  input  wire logic signed [7:0]    rf_sample,
  input  wire logic                 rf_valid,
  input  wire logic                 pll_locked,
  // Analog settings and hold controls
  output logic      [3:0]           gain_code,
  output logic signed [6:0]         offset_comp_value,
  output rf_loop_pkg::hold_t        hold,
  output logic                      pll_fast_bw,
  output logic                      slicer_fast_bw,
  output logic                      defect_raw,
  output logic                      defect_processed,
  output logic                      defect_irq
);
  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic [7:0]  adr_ff;
  logic        wr_ph_ff, rd_ph_ff, hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff;
  wire         acc_go = hsel && hready && htrans[1];
  wire  [7:0]  nxt_adr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : rf_loop_pkg::BAD_ADDR;

  // Reads take one wait state so that a read right after a write sees it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adr_ff       <= 8'h00;
      wr_ph_ff     <= 1'b0;
      rd_ph_ff     <= 1'b0;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      if (acc_go)
        adr_ff <= nxt_adr;
      wr_ph_ff     <= acc_go && hwrite;
      rd_ph_ff     <= acc_go && !hwrite;
      hreadyout_ff <= !(acc_go && !hwrite);
    end
  end

  wire wr_go = wr_ph_ff;
  wire w_ctrl = wr_go && adr_ff == rf_loop_pkg::CTRL_ADDR;
  wire w_ocmp = wr_go && adr_ff == rf_loop_pkg::OCOMP_ADDR;
  wire w_obw  = wr_go && adr_ff == rf_loop_pkg::OBW_ADDR;
  wire w_ohi  = wr_go && adr_ff == rf_loop_pkg::OHI_ADDR;
  wire w_olo  = wr_go && adr_ff == rf_loop_pkg::OLO_ADDR;
  wire w_owin = wr_go && adr_ff == rf_loop_pkg::OWIN_ADDR;
  wire w_athr = wr_go && adr_ff == rf_loop_pkg::ATHR_ADDR;
  wire w_gain = wr_go && adr_ff == rf_loop_pkg::GAIN_ADDR;
  wire w_gbw  = wr_go && adr_ff == rf_loop_pkg::GBW_ADDR;
  wire w_pkbw = wr_go && adr_ff == rf_loop_pkg::PKBW_ADDR;
  wire w_dthr = wr_go && adr_ff == rf_loop_pkg::DTHR_ADDR;
  wire w_hold = wr_go && adr_ff == rf_loop_pkg::HOLD_ADDR;
  wire w_dly  = wr_go && adr_ff == rf_loop_pkg::DLY_ADDR;
  wire w_fast = wr_go && adr_ff == rf_loop_pkg::FAST_ADDR;
  wire w_irq  = wr_go && adr_ff == rf_loop_pkg::IRQ_ADDR;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [4:0]        ctrl_ff;
  logic [3:0]        obw_ff, gbw_ff;
  logic signed [7:0] ohi_ff, olo_ff;
  logic [8:0]        owin_ff;
  logic [15:0]       athr_ff, dthr_ff;
  logic [7:0]        pkbw_ff;
  logic [10:0]       hen_ff;
  logic [31:0]       dly_ff;
  logic [17:0]       fast_ff;
  logic [3:0]        irq_en_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff   <= 5'h00;
      obw_ff    <= 4'h0;
      gbw_ff    <= 4'h0;
      ohi_ff    <= rf_loop_pkg::OFFS_MAX;
      olo_ff    <= rf_loop_pkg::OFFS_MIN;
      owin_ff   <= rf_loop_pkg::OWIN_RST;
      athr_ff   <= rf_loop_pkg::ATHR_RST;
      dthr_ff   <= rf_loop_pkg::DTHR_RST;
      pkbw_ff   <= rf_loop_pkg::PKBW_RST;
      hen_ff    <= 11'h000;
      dly_ff    <= 32'h00000000;
      fast_ff   <= 18'h00000;
      irq_en_ff <= 4'h0;
    end
    else
    begin
      if (w_ctrl) ctrl_ff   <= hwdata[4:0];
      if (w_obw)  obw_ff    <= hwdata[3:0];  // see R04
      if (w_gbw)  gbw_ff    <= hwdata[3:0];
      if (w_ohi)  ohi_ff    <= hwdata[7:0];
      if (w_olo)  olo_ff    <= hwdata[7:0];
      if (w_owin) owin_ff   <= hwdata[8:0];
      if (w_athr) athr_ff   <= hwdata[15:0];
      if (w_dthr) dthr_ff   <= hwdata[15:0];
      if (w_pkbw) pkbw_ff   <= hwdata[7:0];
      if (w_hold) hen_ff    <= hwdata[10:0];
      if (w_dly)  dly_ff    <= hwdata;
      if (w_fast) fast_ff   <= hwdata[17:0];
      if (w_irq)  irq_en_ff <= hwdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // Defect peak detectors and raw flag
  // ------------------------------------------------------------
  logic signed [15:0] lp_ff, mx_ff, mn_ff;
  logic               raw_ff, proc_ff;
  logic [DLY_W-1:0]   cnt_ff;
  logic [WIN_W-1:0]   fcnt_ff;
  wire  signed [15:0] x16   = {rf_sample, 8'h00};
  wire  [4:0]         decay = 5'(pkbw_ff[3:0]) + 5'(rf_loop_pkg::DECAY_BASE);
  wire  signed [15:0] nxt_lp = lp_ff + 16'((17'(x16) - 17'(lp_ff)) >>> pkbw_ff[7:4]);  // see R11
  wire  signed [15:0] nxt_mx = (lp_ff > mx_ff) ? lp_ff : mx_ff - 16'((17'(mx_ff) - 17'(lp_ff)) >>> decay);
  wire  signed [15:0] nxt_mn = (lp_ff < mn_ff) ? lp_ff : mn_ff + 16'((17'(lp_ff) - 17'(mn_ff)) >>> decay);
  wire  [16:0]        span  = 17'(17'(mx_ff) - 17'(mn_ff));
  wire  [7:0]         amp   = (span[16] || span[15:8] == 8'h00) ? 8'h00 : span[15:8];
  wire                nxt_raw = (amp < dthr_ff[7:0]) ? 1'b1 :  // see R12
                                (amp > dthr_ff[15:8]) ? 1'b0 : raw_ff;  // see R13

  // ------------------------------------------------------------
  // Start and stop delays
  // ------------------------------------------------------------
  wire  [DLY_W-1:0] start_dly = dly_ff[DLY_W-1:0];
  wire  [DLY_W-1:0] stop_dly  = dly_ff[rf_loop_pkg::STOP_LSB +: DLY_W];
  wire              mism      = nxt_raw != proc_ff;
  wire              flip      = mism && cnt_ff >= (proc_ff ? stop_dly : start_dly);  // see R17 R18
  wire              nxt_proc  = flip ? nxt_raw : proc_ff;  // see R19
  wire  [DLY_W-1:0] nxt_cnt   = (mism && !flip) ? cnt_ff + 1'b1 : '0;
  wire              proc_end  = proc_ff && !nxt_proc;
  wire  [WIN_W-1:0] nxt_fcnt  = proc_end ? fast_ff[WIN_W-1:0] :  // see R20
                                (fcnt_ff != '0) ? fcnt_ff - 1'b1 : fcnt_ff;
  wire  [3:0]       events    = {proc_end, nxt_proc && !proc_ff, raw_ff && !nxt_raw, nxt_raw && !raw_ff};

  // ------------------------------------------------------------
  // Hold and bandwidth selection
  // ------------------------------------------------------------
  wire                lock_ok = !(ctrl_ff[rf_loop_pkg::LOCK_ONLY_BIT] && !pll_locked);  // see R08
  rf_loop_pkg::hold_t nxt_hold;
  assign nxt_hold.pll    = (nxt_proc && hen_ff[0]) || hen_ff[rf_loop_pkg::FORCE_LSB];  // see R14 R15
  assign nxt_hold.slicer = (nxt_proc && hen_ff[1]) || hen_ff[rf_loop_pkg::FORCE_LSB + 1];
  assign nxt_hold.gain   = nxt_proc && hen_ff[2] && lock_ok;
  assign nxt_hold.offs   = nxt_proc && hen_ff[3] && lock_ok;
  assign nxt_hold.hpf    = (nxt_proc && hen_ff[4]) || hen_ff[rf_loop_pkg::FORCE_LSB + 2];

  rf_loop_pkg::hold_t hold_ff;
  logic               pfast_ff, sfast_ff, irq_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lp_ff    <= 16'sh0000;
      mx_ff    <= 16'sh0000;
      mn_ff    <= 16'sh0000;
      raw_ff   <= 1'b0;
      proc_ff  <= 1'b0;
      cnt_ff   <= '0;
      fcnt_ff  <= '0;
      hold_ff  <= '0;
      pfast_ff <= 1'b0;
      sfast_ff <= 1'b0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      if (rf_valid)
      begin
        lp_ff <= nxt_lp;
        mx_ff <= nxt_mx;
        mn_ff <= nxt_mn;
      end
      raw_ff   <= nxt_raw;
      proc_ff  <= nxt_proc;
      cnt_ff   <= nxt_cnt;
      fcnt_ff  <= nxt_fcnt;
      hold_ff  <= nxt_hold;
      pfast_ff <= nxt_fcnt != '0 && fast_ff[rf_loop_pkg::FAST_PLL_BIT];
      sfast_ff <= nxt_fcnt != '0 && fast_ff[rf_loop_pkg::FAST_SLC_BIT];
      irq_ff   <= |(events & irq_en_ff);  // see R21
    end
  end

  // ------------------------------------------------------------
  // Gain (0) and offset (1) regulation loops
  // ------------------------------------------------------------
  localparam int AW = rf_loop_pkg::FRAC + 3;
  localparam logic signed [AW-1:0] ONE = AW'(1) <<< rf_loop_pkg::FRAC;
  wire  signed [7:0] swin = 8'(owin_ff[7:0]);
  wire               oinv = owin_ff[rf_loop_pkg::INV_BIT];
  wire               o_hi = meas.valid && meas.offs > swin;
  wire               o_lo = meas.valid && meas.offs < -swin;
  wire               g_dn = meas.valid && (meas.clip || meas.amp > athr_ff[15:8]);  // see R24
  wire               g_up = meas.valid && !g_dn && meas.amp < athr_ff[7:0];
  wire         [1:0] up   = {oinv ? o_hi : o_lo, g_up};  // see R22
  wire         [1:0] dn   = {oinv ? o_lo : o_hi, g_dn};
  wire         [1:0] en   = {ctrl_ff[rf_loop_pkg::OFFS_EN_BIT], ctrl_ff[rf_loop_pkg::GAIN_EN_BIT]};  // see R06
  wire         [1:0] slow = {ctrl_ff[rf_loop_pkg::OFFS_SLOW_BIT], ctrl_ff[rf_loop_pkg::GAIN_SLOW_BIT]};
  wire         [1:0] held = {hold_ff.offs, hold_ff.gain};
  wire         [1:0] wr   = {w_ocmp, w_gain};
  wire         [3:0] bw   [2];
  wire  signed [7:0] lo   [2];
  wire  signed [7:0] hi   [2];
  logic signed [7:0] val_ff [2];
  logic signed [AW-1:0] acc_ff [2];
  assign bw[0] = gbw_ff;
  assign bw[1] = obw_ff;
  assign lo[0] = rf_loop_pkg::GAIN_MIN;
  assign hi[0] = rf_loop_pkg::GAIN_MAX;
  assign lo[1] = (olo_ff < rf_loop_pkg::OFFS_MIN) ? rf_loop_pkg::OFFS_MIN : olo_ff;  // see R23
  assign hi[1] = (ohi_ff > rf_loop_pkg::OFFS_MAX) ? rf_loop_pkg::OFFS_MAX : ohi_ff;

  for (genvar i = 0; i < 2; i++)
  begin : g_loop
    logic signed [AW-1:0] step, sum, nxt_acc;
    logic signed [7:0]    cand, nxt_val;
    always_comb
    begin
      step = ONE >>> (5'(bw[i]) + (slow[i] ? 5'(rf_loop_pkg::SLOW_SHIFT) : 5'd0));  // see R07
      sum  = acc_ff[i] + (up[i] ? step : dn[i] ? -step : '0);  // see R01
      cand = val_ff[i];
      nxt_acc = sum;
      if (sum >= ONE)
      begin
        nxt_acc = (val_ff[i] < hi[i]) ? sum - ONE : ONE;  // see R02
        cand    = (val_ff[i] < hi[i]) ? val_ff[i] + 8'sh01 : val_ff[i];
      end
      else if (sum <= -ONE)
      begin
        nxt_acc = (val_ff[i] > lo[i]) ? sum + ONE : -ONE;
        cand    = (val_ff[i] > lo[i]) ? val_ff[i] - 8'sh01 : val_ff[i];
      end
      if (wr[i])
      begin
        cand    = 8'(hwdata[7:0]);  // see R03
        nxt_acc = '0;
      end
      else if (!en[i] || held[i])
      begin
        cand    = val_ff[i];  // see R16 R25
        nxt_acc = acc_ff[i];
      end
      nxt_val = (cand > hi[i]) ? hi[i] : (cand < lo[i]) ? lo[i] : cand;  // see R05
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        val_ff[i] <= 8'sh00;
        acc_ff[i] <= '0;
      end
      else
      begin
        val_ff[i] <= nxt_val;
        acc_ff[i] <= nxt_acc;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  wire [31:0] stat = {21'h0, pfast_ff || sfast_ff, proc_ff, raw_ff, amp};
  wire [31:0] rd_mux =
    (adr_ff == rf_loop_pkg::CTRL_ADDR)  ? 32'(ctrl_ff) :
    (adr_ff == rf_loop_pkg::OCOMP_ADDR) ? 32'(val_ff[1][7:0]) :
    (adr_ff == rf_loop_pkg::OBW_ADDR)   ? 32'(obw_ff) :
    (adr_ff == rf_loop_pkg::OHI_ADDR)   ? 32'(ohi_ff[7:0]) :
    (adr_ff == rf_loop_pkg::OLO_ADDR)   ? 32'(olo_ff[7:0]) :
    (adr_ff == rf_loop_pkg::OWIN_ADDR)  ? 32'(owin_ff) :
    (adr_ff == rf_loop_pkg::ATHR_ADDR)  ? 32'(athr_ff) :
    (adr_ff == rf_loop_pkg::GAIN_ADDR)  ? 32'(val_ff[0][7:0]) :
    (adr_ff == rf_loop_pkg::GBW_ADDR)   ? 32'(gbw_ff) :
    (adr_ff == rf_loop_pkg::PKBW_ADDR)  ? 32'(pkbw_ff) :
    (adr_ff == rf_loop_pkg::DTHR_ADDR)  ? 32'(dthr_ff) :
    (adr_ff == rf_loop_pkg::HOLD_ADDR)  ? 32'(hen_ff) :
    (adr_ff == rf_loop_pkg::DLY_ADDR)   ? dly_ff :
    (adr_ff == rf_loop_pkg::FAST_ADDR)  ? 32'(fast_ff) :
    (adr_ff == rf_loop_pkg::IRQ_ADDR)   ? 32'(irq_en_ff) :
    (adr_ff == rf_loop_pkg::STAT_ADDR)  ? stat : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h00000000;
    else if (rd_ph_ff)
      hrdata_ff <= rd_mux;
  end

  assign hrdata            = hrdata_ff;
  assign hreadyout         = hreadyout_ff;
  assign hresp             = hresp_ff;
  assign gain_code         = val_ff[0][3:0];
  assign offset_comp_value = val_ff[1][6:0];
  assign hold              = hold_ff;
  assign pll_fast_bw       = pfast_ff;
  assign slicer_fast_bw    = sfast_ff;
  assign defect_raw        = raw_ff;
  assign defect_processed  = proc_ff;
  assign defect_irq        = irq_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_raw_low_set: assert property (amp < dthr_ff[7:0] |=> raw_ff)  // see R12
    else $error("defect flag not set below low threshold");
  chk_raw_high_clear: assert property (raw_ff && amp <= dthr_ff[15:8] |=> raw_ff)  // see R13
    else $error("defect flag cleared without passing high threshold");
  chk_proc_zero_dly: assert property ($past(dly_ff) == 32'h0 |-> proc_ff == raw_ff)  // see R19
    else $error("processed defect differs from raw with zero delays");
  chk_start_delay_count: assert property ($rose(proc_ff) |-> $past(cnt_ff) == $past(start_dly))  // see R17
    else $error("processed defect rose before start delay");
  chk_stop_delay_count: assert property ($fell(proc_ff) |-> $past(cnt_ff) == $past(stop_dly))  // see R18
    else $error("processed defect fell before stop delay");
  chk_offset_in_bounds: assert property ($past(lo[1] <= hi[1])  // see R05
    |-> val_ff[1] <= $past(hi[1]) && val_ff[1] >= $past(lo[1]))
    else $error("offset value outside bounds");
  chk_offset_frozen: assert property ((!en[1] || held[1]) && !wr[1]  // see R25
    && lo[1] <= val_ff[1] && val_ff[1] <= hi[1] |=> $stable(val_ff[1]) && $stable(acc_ff[1]))
    else $error("held offset loop moved");
  chk_offset_one_step: assert property (!wr[1] && $stable(olo_ff) && $stable(ohi_ff)  // see R02
    |=> val_ff[1] - $past(val_ff[1]) <= 8'sh01 && $past(val_ff[1]) - val_ff[1] <= 8'sh01)
    else $error("offset value moved more than one step");
  chk_hold_lock_gate: assert property (ctrl_ff[rf_loop_pkg::LOCK_ONLY_BIT] && !pll_locked  // see R08
    |=> !hold_ff.gain && !hold_ff.offs)
    else $error("loop held while PLL unlocked");
  chk_force_pll_hold: assert property (hen_ff[rf_loop_pkg::FORCE_LSB] |=> hold_ff.pll)  // see R15
    else $error("forced PLL hold missing");
  chk_read_one_wait: assert property (acc_go && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  cov_proc_defect: cover property ($rose(proc_ff) ##[1:50] $fell(proc_ff));
  cov_fast_window: cover property ($rose(pfast_ff));
  cov_irq_pulse: cover property (irq_ff);
  cov_offset_step: cover property (en[1] && !$stable(val_ff[1]));
endmodule  // rf_defect_loops
`default_nettype wire

// ### logic/rf_loop_pkg.sv
`default_nettype none
package rf_loop_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] OCOMP_ADDR = 8'h04;
  localparam logic [7:0] OBW_ADDR   = 8'h08;
  localparam logic [7:0] OHI_ADDR   = 8'h0c;
  localparam logic [7:0] OLO_ADDR   = 8'h10;
  localparam logic [7:0] OWIN_ADDR  = 8'h14;
  localparam logic [7:0] ATHR_ADDR  = 8'h18;
  localparam logic [7:0] GAIN_ADDR  = 8'h1c;
  localparam logic [7:0] GBW_ADDR   = 8'h20;
  localparam logic [7:0] PKBW_ADDR  = 8'h24;
  localparam logic [7:0] DTHR_ADDR  = 8'h28;
  localparam logic [7:0] HOLD_ADDR  = 8'h2c;
  localparam logic [7:0] DLY_ADDR   = 8'h30;
  localparam logic [7:0] FAST_ADDR  = 8'h34;
  localparam logic [7:0] IRQ_ADDR   = 8'h38;
  localparam logic [7:0] STAT_ADDR  = 8'h3c;
  localparam logic [7:0] BAD_ADDR   = 8'hff;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int GAIN_EN_BIT   = 0;
  localparam int OFFS_EN_BIT   = 1;
  localparam int GAIN_SLOW_BIT = 2;
  localparam int OFFS_SLOW_BIT = 3;
  localparam int LOCK_ONLY_BIT = 4;
  localparam int INV_BIT       = 8;
  localparam int FORCE_LSB     = 8;
  localparam int FAST_PLL_BIT  = 16;
  localparam int FAST_SLC_BIT  = 17;
  localparam int STOP_LSB      = 16;
  // ------------------------------------------------------------
  // Loop constants and reset values
  // ------------------------------------------------------------
  localparam int              FRAC       = 24;
  localparam int              SLOW_SHIFT = 7;
  localparam int              DECAY_BASE = 6;
  localparam logic signed [7:0] OFFS_MAX = 8'sh20;
  localparam logic signed [7:0] OFFS_MIN = -8'sh20;
  localparam logic signed [7:0] GAIN_MAX = 8'sh0f;
  localparam logic signed [7:0] GAIN_MIN = 8'sh00;
  localparam logic [8:0]  OWIN_RST = 9'h008;
  localparam logic [15:0] ATHR_RST = 16'h6040;
  localparam logic [15:0] DTHR_RST = 16'h3020;
  localparam logic [7:0]  PKBW_RST = 8'h24;

  typedef struct packed {
    logic              valid;
    logic              clip;
    logic [7:0]        amp;
    logic signed [7:0] offs;
  } meas_t;

  typedef struct packed {
    logic pll;
    logic slicer;
    logic gain;
    logic offs;
    logic hpf;
  } hold_t;
endpackage
`default_nettype wire

// ### testbench/rf_front_model.sv
`default_nettype none
module rf_front_model (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Scenario controls
  input  wire logic [6:0]         swing,
  input  wire logic signed [7:0]  offs_level,
  // Toward the loop block
  output rf_loop_pkg::meas_t      meas,
  output logic signed [7:0]       rf_sample,
  output logic                    rf_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_ff;
  // Samples alternate in sign so both peak trackers see the swing
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      phase_ff  <= 3'h0;
      rf_valid  <= 1'b0;
      rf_sample <= 8'sh00;
      meas      <= '0;
    end
    else
    begin
      phase_ff   <= phase_ff + 3'h1;
      rf_valid   <= phase_ff[0];
      rf_sample  <= phase_ff[1] ? $signed({1'b0, swing}) : -$signed({1'b0, swing});
      meas.valid <= (phase_ff == 3'h7);
      meas.clip  <= 1'b0;
      // Amplitude between the gain thresholds keeps the gain loop quiet
      meas.amp   <= 8'h50;
      meas.offs  <= offs_level;
    end
endmodule // rf_front_model
`default_nettype wire

// ### testbench/rf_defect_loops_test.sv
`default_nettype none
module rf_defect_loops_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn, hsel, hwrite, hreadyout, hresp, rf_valid, pll_locked;
  logic [31:0] haddr, hwdata, hrdata, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] gain_code;
  logic signed [6:0] offset_comp_value;
  logic signed [7:0] rf_sample, offs_level;
  logic [6:0] swing;
  logic pll_fast_bw, slicer_fast_bw, defect_raw, defect_processed, defect_irq;
  rf_loop_pkg::meas_t meas;
  rf_loop_pkg::hold_t hold;
  int n_errors = 0, samples_checked = 0, fast_n = 0, irq_n = 0;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    if (pll_fast_bw === 1'b1 && slicer_fast_bw === 1'b1) fast_n++;
    if (defect_irq === 1'b1) irq_n++;
  end
  rf_defect_loops DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas(meas), .rf_sample(rf_sample), .rf_valid(rf_valid),
    .pll_locked(pll_locked), .gain_code(gain_code), .offset_comp_value(offset_comp_value), .hold(hold),
    .pll_fast_bw(pll_fast_bw), .slicer_fast_bw(slicer_fast_bw), .defect_raw(defect_raw),
    .defect_processed(defect_processed), .defect_irq(defect_irq));
  rf_front_model front (.hclk(hclk), .hresetn(hresetn), .swing(swing), .offs_level(offs_level),
    .meas(meas), .rf_sample(rf_sample), .rf_valid(rf_valid));
  task check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Ready is looked at mid-cycle, where it is settled, then the edge is taken
  task wait_ready;
    forever
    begin
      @(negedge hclk);
      if (hreadyout === 1'b1) break;
    end
    @(posedge hclk);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel   <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    got = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    check(got === e && hresp === 1'b0, m);
  endtask
  task dly_check(input logic lvl, input int d);
    int n;
    n = 0;
    while (defect_raw !== lvl) begin @(posedge hclk); #1; end
    while (defect_processed !== lvl) begin @(posedge hclk); #1; n++; end
    check(n == d, "processed delay");
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    pll_locked = 1; swing = 0; offs_level = 0; hresetn = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(rf_loop_pkg::OLO_ADDR, 32'he0, "lower bound reset");
    rd_chk(rf_loop_pkg::OHI_ADDR, 32'h20, "upper bound reset");
    rd_chk(rf_loop_pkg::DTHR_ADDR, 32'h3020, "defect thresholds reset");
    rd_chk(rf_loop_pkg::BAD_ADDR, 32'h0, "unmapped read");
    $display("register test done");
    wr(rf_loop_pkg::PKBW_ADDR, 32'h0);
    wr(rf_loop_pkg::OBW_ADDR, 32'h0);
    wr(rf_loop_pkg::OLO_ADDR, 32'hfffffffd);
    wr(rf_loop_pkg::OHI_ADDR, 32'h2);
    wr(rf_loop_pkg::IRQ_ADDR, 32'h3);
    wr(rf_loop_pkg::FAST_ADDR, 32'h00030004);
    wr(rf_loop_pkg::DLY_ADDR, 32'h00030005);
    offs_level <= 8'sd50;
    wr(rf_loop_pkg::CTRL_ADDR, 32'h2);
    repeat (300) @(posedge hclk);
    rd_chk(rf_loop_pkg::OCOMP_ADDR, 32'hfd, "offset down to lower bound");
    check(offset_comp_value === -7'sd3, "applied offset");
    wr(rf_loop_pkg::OWIN_ADDR, 32'h108);
    repeat (300) @(posedge hclk);
    rd_chk(rf_loop_pkg::OCOMP_ADDR, 32'h02, "inverted offset up to upper bound");
    wr(rf_loop_pkg::CTRL_ADDR, 32'h0);
    wr(rf_loop_pkg::OCOMP_ADDR, 32'h1);
    repeat (100) @(posedge hclk);
    rd_chk(rf_loop_pkg::OCOMP_ADDR, 32'h01, "disabled loop keeps value");
    wr(rf_loop_pkg::ATHR_ADDR, 32'h7058);
    wr(rf_loop_pkg::CTRL_ADDR, 32'h1);
    repeat (200) @(posedge hclk);
    check(gain_code === 4'hf, "gain up to top bound");
    rd_chk(rf_loop_pkg::OCOMP_ADDR, 32'h01, "offset untouched by gain enable");
    wr(rf_loop_pkg::CTRL_ADDR, 32'h5);
    wr(rf_loop_pkg::GAIN_ADDR, 32'h0);
    repeat (900) @(posedge hclk);
    check(gain_code === 4'h0, "slow gain not yet stepped");
    repeat (300) @(posedge hclk);
    check(gain_code === 4'h1, "slow gain one step");
    $display("offset loop test done");
    wr(rf_loop_pkg::HOLD_ADDR, 32'h8);
    @(posedge hclk);
    #1;
    check(hold.offs === 1'b1, "offset hold on defect");
    swing <= 7'd100;
    dly_check(1'b0, 3);
    check(hold.offs === 1'b0, "hold released");
    swing <= 7'd0;
    dly_check(1'b1, 5);
    check(hold.offs === 1'b1 && hold.pll === 1'b0, "hold follows processed");
    wr(rf_loop_pkg::HOLD_ADDR, 32'h100);
    @(posedge hclk);
    #1;
    check(hold.pll === 1'b1 && hold.offs === 1'b0, "forced pll hold");
    check(fast_n == 4, "fast window length");
    check(irq_n == 2, "raw start and end pulses");
    wr(rf_loop_pkg::HOLD_ADDR, 32'h8);
    wr(rf_loop_pkg::CTRL_ADDR, 32'h12);
    pll_locked <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    check(hold.offs === 1'b0, "no hold while unlocked");
    pll_locked <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    check(hold.offs === 1'b1, "hold when locked");
    $display("defect test done");
    wrap_up();
  end
endmodule // rf_defect_loops_test
`default_nettype wire
